// ---- hdl/serial_eeprom_defines.vh ----
`ifndef SERIAL_EEPROM_DEFINES_VH
`define SERIAL_EEPROM_DEFINES_VH

// ****************************************
// Opcodes
// ****************************************
`define OPC_SET_WRITE_LATCH   8'h06
`define OPC_CLEAR_WRITE_LATCH 8'h04
`define OPC_STATUS_READ       8'h05
`define OPC_STATUS_WRITE      8'h01
`define OPC_MEM_READ          8'h03
`define OPC_MEM_WRITE         8'h02

// ****************************************
// Status byte layout
// ****************************************
`define ST_LOCK_POS   7
`define ST_GUARD_HI   3
`define ST_GUARD_LO   2
`define ST_LATCH_POS  1
`define ST_BUSY_POS   0

// ****************************************
// Reset values of nonvolatile bits
// ****************************************
`define RST_LOCK      1'b0
`define RST_GUARD     2'h0

// ****************************************
// Clock counts within a selection
// ****************************************
`define CNT_OPC_END   6'h08
`define CNT_STAT_END  6'h10
`define CNT_ADDR_END  6'h18
`define CNT_DATA_END  6'h20
`define CNT_STAT_WRAP 6'h09
`define CNT_DATA_WRAP 6'h19
`define CNT_SAT       6'h3F

// ****************************************
// Guarded array regions
// ****************************************
`define PROT_QUARTER_BASE 14'h3000
`define PROT_HALF_BASE    14'h2000

`endif

// ---- hdl/bit_sync.v ----
`timescale 1ns/1ns

// ****************************************
// Two-stage synchroniser
// ****************************************
module bit_sync #(
    parameter WIDTH = 6
) (
    input  wire             clk,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta;

    // No reset: stage one must feed stage two only
    always @(posedge clk) begin
        meta <= din;
        dout <= meta;
    end
endmodule

// ---- hdl/sck_pause_gate.v ----
`timescale 1ns/1ns

// ****************************************
// Serial clock edges and pause tracking
// ****************************************
module sck_pause_gate (
    input  wire clk,
    input  wire reset,
    input  wire sck_s,
    input  wire hold_n_s,
    output wire rise,
    output wire fall,
    output reg  paused
);
    reg sck_d;

    // Pause follows hold only while the clock is low
    always @(posedge clk) begin
        if (reset) begin
            sck_d  <= 1'b0;
            paused <= 1'b0;
        end else begin
            sck_d <= sck_s;
            if (!sck_s) begin
                paused <= ~hold_n_s; // RL26
            end
        end
    end

    // Edges are dropped while paused
    assign rise = sck_s & ~sck_d & ~paused; // RL23
    assign fall = ~sck_s & sck_d & ~paused; // RL23
endmodule

// ---- hdl/serial_eeprom_cmd_status.v ----
`timescale 1ns/1ns
`include "serial_eeprom_defines.vh"

// Function
// RL1 - Chip select high: deselected, output off
// RL2 - Sample input on serial clock rise
// RL3 - Update output on serial clock fall
// RL4 - Opcode is first byte, MSB first
// RL5 - Unknown opcode ignored until deselect
// RL6 - Latch and status opcodes; status byte 9-16
// RL7 - Memory opcodes, address 9-24, data 25-32
// RL8 - Memory read continues at next address
// RL9 - Status byte bit layout, b6-b4 zero
// RL10 - Lock bit plus protect low: hardware lock
// RL11 - Guard bits protect regions, writable unless locked
// RL12 - Latch set only by set command
// RL13 - No latch: writes rejected
// RL14 - Latch cleared by reset, droop, clear, completion
// RL15 - Busy flag shows internal write
// RL16 - Set latch needs exactly 8 clocks
// RL17 - Clear latch needs exactly 8 clocks
// RL18 - Status read always; nonvolatile bits snapshotted
// RL19 - Status read repeats while clocked
// RL20 - Status write changes lock and guards only
// RL21 - Status write needs exactly 16 clocks
// RL22 - New status values apply on completion
// RL23 - Pause: output off, clock ignored
// RL24 - Guard bit region map
// RL25 - Write address wraps within 64-byte page
// RL26 - Pause changes only while clock low
// RL27 - Deselect clears counter and decoder
module serial_eeprom_cmd_status (
    input  wire        clk,
    input  wire        reset,
    input  wire        cs_n,
    input  wire        sck,
    input  wire        si,
    input  wire        hold_n,
    input  wire        wp_n,
    input  wire        supply_droop,
    input  wire [7:0]  mem_rd_data,
    input  wire        nv_write_done,
    output reg         so,
    output wire        so_oe,
    output reg         write_busy_flag,
    output reg         hardware_lock_mode,
    output reg  [13:0] mem_addr,
    output reg         mem_rd_req,
    output reg         mem_wr_strobe,
    output reg  [7:0]  mem_wr_data,
    output reg         nv_write_start
);
    // ****************************************
    // States
    // ****************************************
    localparam ST_OPC    = 3'h0;
    localparam ST_LATCH  = 3'h1;
    localparam ST_SREAD  = 3'h2;
    localparam ST_SWRITE = 3'h3;
    localparam ST_MREAD  = 3'h4;
    localparam ST_MWRITE = 3'h5;
    localparam ST_IGNORE = 3'h6;

    // ****************************************
    // Functions
    // ****************************************
    function guarded;
        input [13:0] a;
        input [1:0]  g;
        begin
            case (g)
                2'h0:    guarded = 1'b0;
                2'h1:    guarded = (a >= `PROT_QUARTER_BASE);
                2'h2:    guarded = (a >= `PROT_HALF_BASE);
                default: guarded = 1'b1;
            endcase
        end
    endfunction

    function [7:0] status_byte;
        input       lock;
        input [1:0] g;
        input       latch;
        input       busy;
        begin
            status_byte                = 8'h00; // RL9
            status_byte[`ST_LOCK_POS]  = lock;
            status_byte[`ST_GUARD_HI]  = g[1];
            status_byte[`ST_GUARD_LO]  = g[0];
            status_byte[`ST_LATCH_POS] = latch;
            status_byte[`ST_BUSY_POS]  = busy;
        end
    endfunction

    // ****************************************
    // Pin synchronisers and edges
    // ****************************************
    wire [5:0] pins_s;
    wire       cs_s;
    wire       sck_s;
    wire       si_s;
    wire       hold_n_s;
    wire       wp_s;
    wire       droop_s;
    wire       rise;
    wire       fall;
    wire       paused;

    bit_sync #(
        .WIDTH (6)
    ) u_sync (
        .clk  (clk),
        .din  ({supply_droop, wp_n, hold_n, si, sck, cs_n}),
        .dout (pins_s)
    );

    assign cs_s     = pins_s[0];
    assign sck_s    = pins_s[1];
    assign si_s     = pins_s[2];
    assign hold_n_s = pins_s[3];
    assign wp_s     = pins_s[4];
    assign droop_s  = pins_s[5];

    sck_pause_gate u_gate (
        .clk      (clk),
        .reset    (reset),
        .sck_s    (sck_s),
        .hold_n_s (hold_n_s),
        .rise     (rise),
        .fall     (fall),
        .paused   (paused)
    );

    // ****************************************
    // State
    // ****************************************
    reg  [2:0]  state;
    reg  [5:0]  cnt;
    reg  [7:0]  in_sh;
    reg  [15:0] addr_sh;
    reg  [7:0]  out_sh;
    reg         out_valid;
    reg         cs_d;
    reg         latch_set_cmd;
    reg  [7:0]  stat_data;
    reg         byte_seen;
    reg         lock_bit;
    reg  [1:0]  guard_bits;
    reg         write_latch_bit;
    reg         nv_pending;
    reg         pend_lock;
    reg  [1:0]  pend_guard;
    reg         snap_lock;
    reg  [1:0]  snap_guard;
    wire [7:0]  in_byte;
    wire [13:0] in_addr;
    wire        cs_rise;
    wire        hw_lock;

    assign in_byte = {in_sh[6:0], si_s};
    assign in_addr = {addr_sh[12:0], si_s};
    assign cs_rise = cs_s & ~cs_d;
    assign hw_lock = lock_bit & ~wp_s; // RL10

    // Output enabled only when selected, unpaused and sending
    assign so_oe = ~cs_s & ~paused & out_valid
                 & ((state == ST_SREAD) | (state == ST_MREAD)); // RL1 RL23

    // ****************************************
    // Command engine
    // ****************************************
    always @(posedge clk) begin
        if (reset) begin
            state              <= ST_OPC;
            cnt                <= 6'h00;
            in_sh              <= 8'h00;
            addr_sh            <= 16'h0000;
            out_sh             <= 8'h00;
            out_valid          <= 1'b0;
            cs_d               <= 1'b1;
            latch_set_cmd      <= 1'b0;
            stat_data          <= 8'h00;
            byte_seen          <= 1'b0;
            lock_bit           <= `RST_LOCK;
            guard_bits         <= `RST_GUARD;
            write_latch_bit    <= 1'b0; // RL14
            nv_pending         <= 1'b0;
            pend_lock          <= `RST_LOCK;
            pend_guard         <= `RST_GUARD;
            snap_lock          <= `RST_LOCK;
            snap_guard         <= `RST_GUARD;
            so                 <= 1'b0;
            write_busy_flag    <= 1'b0;
            hardware_lock_mode <= 1'b0;
            mem_addr           <= 14'h0000;
            mem_rd_req         <= 1'b0;
            mem_wr_strobe      <= 1'b0;
            mem_wr_data        <= 8'h00;
            nv_write_start     <= 1'b0;
        end else begin
            cs_d               <= cs_s;
            hardware_lock_mode <= hw_lock;
            mem_rd_req         <= 1'b0;
            mem_wr_strobe      <= 1'b0;
            nv_write_start     <= 1'b0;
            so                 <= out_sh[7];

            // Completion first, so a latch set in the same cycle wins
            if (nv_write_done && write_busy_flag) begin
                write_busy_flag <= 1'b0; // RL15
                write_latch_bit <= 1'b0; // RL14
                nv_pending      <= 1'b0;
                if (nv_pending) begin
                    lock_bit   <= pend_lock; // RL22
                    guard_bits <= pend_guard;
                end
            end

            if (cs_s) begin
                state     <= ST_OPC; // RL27
                cnt       <= 6'h00;
                out_valid <= 1'b0;
                byte_seen <= 1'b0;
                if (cs_rise) begin
                    case (state)
                        ST_LATCH: begin
                            if (cnt == `CNT_OPC_END) begin
                                write_latch_bit <= latch_set_cmd; // RL12 RL16 RL17
                            end
                        end
                        ST_SWRITE: begin
                            if (cnt == `CNT_STAT_END) begin // RL21
                                nv_pending      <= 1'b1;
                                pend_lock       <= stat_data[`ST_LOCK_POS]; // RL20
                                pend_guard      <= {stat_data[`ST_GUARD_HI],
                                                    stat_data[`ST_GUARD_LO]};
                                write_busy_flag <= 1'b1; // RL15
                                nv_write_start  <= 1'b1;
                            end
                        end
                        ST_MWRITE: begin
                            if (cnt == `CNT_DATA_END && byte_seen) begin
                                write_busy_flag <= 1'b1; // RL15
                                nv_write_start  <= 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end else begin
                if (rise) begin
                    in_sh <= in_byte; // RL2
                    if (cnt >= `CNT_OPC_END && cnt < `CNT_ADDR_END) begin
                        addr_sh <= {addr_sh[14:0], si_s};
                    end
                    // Wrap keeps byte boundaries visible in long transfers
                    if (state == ST_SREAD && cnt == `CNT_STAT_END) begin
                        cnt <= `CNT_STAT_WRAP;
                    end else if ((state == ST_MREAD || state == ST_MWRITE)
                                 && cnt == `CNT_DATA_END) begin
                        cnt <= `CNT_DATA_WRAP;
                    end else if (cnt != `CNT_SAT) begin
                        cnt <= cnt + 6'h01;
                    end
                    if (cnt == `CNT_OPC_END - 6'h01 && state == ST_OPC) begin
                        latch_set_cmd <= (in_byte == `OPC_SET_WRITE_LATCH);
                        snap_lock     <= lock_bit; // RL18
                        snap_guard    <= guard_bits;
                        case (in_byte) // RL4 RL6 RL7
                            `OPC_SET_WRITE_LATCH:   state <= ST_LATCH;
                            `OPC_CLEAR_WRITE_LATCH: state <= ST_LATCH;
                            `OPC_STATUS_READ:       state <= ST_SREAD; // RL18
                            `OPC_STATUS_WRITE:
                                state <= (write_latch_bit && !write_busy_flag && !hw_lock)
                                         ? ST_SWRITE : ST_IGNORE; // RL10 RL13
                            `OPC_MEM_READ:
                                state <= write_busy_flag ? ST_IGNORE : ST_MREAD;
                            `OPC_MEM_WRITE:
                                state <= (write_latch_bit && !write_busy_flag)
                                         ? ST_MWRITE : ST_IGNORE; // RL13
                            default:                state <= ST_IGNORE; // RL5
                        endcase
                    end
                    if (cnt == `CNT_STAT_END - 6'h01 && state == ST_SWRITE) begin
                        stat_data <= in_byte;
                    end
                    if (cnt == `CNT_ADDR_END - 6'h01) begin
                        // Top two address bits are dropped
                        mem_addr <= in_addr; // RL7
                        if (state == ST_MREAD) begin
                            mem_rd_req <= 1'b1;
                        end
                        if (state == ST_MWRITE && guarded(in_addr, guard_bits)) begin
                            state <= ST_IGNORE; // RL11 RL24
                        end
                    end
                    if (cnt == `CNT_DATA_END - 6'h01 && state == ST_MWRITE) begin
                        mem_wr_strobe <= 1'b1;
                        mem_wr_data   <= in_byte;
                        byte_seen     <= 1'b1;
                    end
                end
                if (fall) begin
                    if (state == ST_SREAD
                        && (cnt == `CNT_OPC_END || cnt == `CNT_STAT_END)) begin
                        out_sh    <= status_byte(snap_lock, snap_guard,
                                                 write_latch_bit,
                                                 write_busy_flag); // RL19 RL18
                        out_valid <= 1'b1;
                    end else if (state == ST_MREAD
                                 && (cnt == `CNT_ADDR_END || cnt == `CNT_DATA_END)) begin
                        // Next byte fetched a whole byte time ahead
                        out_sh     <= mem_rd_data;
                        out_valid  <= 1'b1;
                        mem_addr   <= mem_addr + 14'h0001; // RL8
                        mem_rd_req <= 1'b1;
                    end else begin
                        out_sh <= {out_sh[6:0], 1'b0}; // RL3
                    end
                    if (state == ST_MWRITE && cnt == `CNT_DATA_END) begin
                        mem_addr[5:0] <= mem_addr[5:0] + 6'h01; // RL25
                    end
                end
            end

            // Droop wins over any latch set in the same cycle
            if (droop_s) begin
                write_latch_bit <= 1'b0; // RL14
            end
        end
    end
endmodule

// ---- testbench/serial_eeprom_cmd_status_checker.sv ----
`timescale 1ns/1ns

// ********
// Port checker
// ********
module serial_eeprom_cmd_status_checker (
    input wire clk,
    input wire reset,
    input wire cs_n,
    input wire sck,
    input wire wp_n,
    input wire supply_droop,
    input wire nv_write_done,
    input wire so,
    input wire so_oe,
    input wire write_busy_flag,
    input wire hardware_lock_mode,
    input wire mem_rd_req,
    input wire mem_wr_strobe,
    input wire nv_write_start
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Sync delay allowed for
    property p_desel_quiet;
        cs_n [*5] |-> !so_oe;
    endproperty
    property p_so_on_fall;
        $changed(so) && so_oe && $past(so_oe) |-> !sck && !$past(sck, 2);
    endproperty
    property p_busy_start;
        nv_write_start |-> ##[0:1] write_busy_flag;
    endproperty
    property p_busy_end;
        write_busy_flag && nv_write_done |=> !write_busy_flag;
    endproperty
    property p_busy_hold;
        write_busy_flag && !nv_write_done && !supply_droop |=> write_busy_flag;
    endproperty
    property p_lock_needs_wp;
        wp_n [*5] |-> !hardware_lock_mode;
    endproperty
    property p_start_deselected;
        nv_write_start |-> cs_n && !$past(write_busy_flag);
    endproperty
    property p_strobe_selected;
        mem_wr_strobe |-> !cs_n && !write_busy_flag;
    endproperty
    property p_read_not_busy;
        mem_rd_req |-> !write_busy_flag;
    endproperty
    a_desel_quiet: assert property (p_desel_quiet) else $error("output on while off");
    a_so_on_fall: assert property (p_so_on_fall) else $error("so moved off fall");
    a_busy_start: assert property (p_busy_start) else $error("busy not set");
    a_busy_end: assert property (p_busy_end) else $error("busy not cleared");
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    a_lock_needs_wp: assert property (p_lock_needs_wp) else $error("lock without wp");
    a_start_deselected: assert property (p_start_deselected) else $error("bad start");
    a_strobe_selected: assert property (p_strobe_selected) else $error("bad strobe");
    a_read_not_busy: assert property (p_read_not_busy) else $error("read while busy");
    c_start: cover property (nv_write_start);
    c_read: cover property (mem_rd_req);
    c_lock: cover property (hardware_lock_mode);
endmodule

bind serial_eeprom_cmd_status serial_eeprom_cmd_status_checker serial_eeprom_cmd_status_checker_inst (
    .clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck), .wp_n(wp_n),
    .supply_droop(supply_droop), .nv_write_done(nv_write_done), .so(so), .so_oe(so_oe),
    .write_busy_flag(write_busy_flag), .hardware_lock_mode(hardware_lock_mode),
    .mem_rd_req(mem_rd_req), .mem_wr_strobe(mem_wr_strobe), .nv_write_start(nv_write_start));

// ---- testbench/spi_host_model.sv ----
`timescale 1ns/1ns

// ********
// Host side of the link
// ********
module spi_host_model (
    input  wire clk,
    input  wire so,
    input  wire so_oe,
    output reg  cs_n,
    output reg  sck,
    output reg  si
);
    reg oe_seen;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        oe_seen = 1'b0;
    end
    task automatic sel;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // Clock idles low between frames
    task automatic shift(input int n, input logic [47:0] tx, output logic [47:0] rx);
        int i;
        rx = '0;
        oe_seen = 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            si <= tx[i];
            repeat (8) @(posedge clk);
            sck <= 1'b1;
            // Released output reads as the inverse of what was last driven
            rx = {rx[46:0], so_oe ? so : ~so};
            oe_seen = oe_seen | so_oe;
            repeat (8) @(posedge clk);
            sck <= 1'b0;
        end
    endtask
    task automatic desel;
        repeat (8) @(posedge clk);
        cs_n <= 1'b1;
        si <= ~si;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ---- testbench/tb_serial_eeprom_cmd_status.sv ----
`timescale 1ns/1ns

module tb_serial_eeprom_cmd_status;
    reg          clk;
    reg          reset;
    reg          hold_n;
    reg          wp_n;
    reg          supply_droop;
    reg  [7:0]   mem_rd_data;
    reg          nv_write_done;
    wire         cs_n;
    wire         sck;
    wire         si;
    wire         so;
    wire         so_oe;
    wire         write_busy_flag;
    wire         hardware_lock_mode;
    wire [13:0]  mem_addr;
    wire         mem_rd_req;
    wire         mem_wr_strobe;
    wire [7:0]   mem_wr_data;
    wire         nv_write_start;
    int          miscompares;
    int          num_checks;
    int          starts;
    logic [21:0] wq[$];
    logic [47:0] rx;

    serial_eeprom_cmd_status serial_eeprom_cmd_status_inst (
        .clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .wp_n(wp_n), .supply_droop(supply_droop), .mem_rd_data(mem_rd_data),
        .nv_write_done(nv_write_done), .so(so), .so_oe(so_oe),
        .write_busy_flag(write_busy_flag), .hardware_lock_mode(hardware_lock_mode),
        .mem_addr(mem_addr), .mem_rd_req(mem_rd_req), .mem_wr_strobe(mem_wr_strobe),
        .mem_wr_data(mem_wr_data), .nv_write_start(nv_write_start));
    spi_host_model spi_host_model_inst (
        .clk(clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ********
    // Array stand-in and monitors
    // ********
    always @(posedge clk) begin
        // Data follows only a fetch request, so a lost request shows up
        if (mem_rd_req === 1'b1)
            mem_rd_data <= mem_addr[7:0] ^ 8'h5A;
        if (nv_write_start === 1'b1)
            starts++;
        if (mem_wr_strobe === 1'b1)
            wq.push_back({mem_addr, mem_wr_data});
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic frame(input int n, input logic [47:0] tx);
        spi_host_model_inst.sel();
        spi_host_model_inst.shift(n, tx, rx);
        spi_host_model_inst.desel();
    endtask
    task automatic status(input logic [7:0] exp);
        frame(24, 48'h050000);
        check(rx[15:8], exp);
        check(rx[7:0], exp);
    endtask
    task automatic finish_write;
        int i;
        for (i = 0; i < 40 && write_busy_flag !== 1'b1; i++)
            @(posedge clk);
        if (write_busy_flag !== 1'b1) begin
            miscompares++;
            complete_run();
        end
        check(write_busy_flag, 1'b1);
        nv_write_done <= 1'b1;
        @(posedge clk);
        nv_write_done <= 1'b0;
        repeat (3) @(posedge clk);
        check(write_busy_flag, 1'b0);
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_latch;
        status(8'h00);
        frame(9, 48'h00C);
        status(8'h00);
        frame(8, 48'h06);
        status(8'h02);
        frame(9, 48'h008);
        status(8'h02);
        frame(8, 48'h04);
        status(8'h00);
    endtask
    task automatic t_stat_write;
        frame(16, 48'h018C);
        check(starts, 0);
        frame(8, 48'h06);
        frame(16, 48'h01F7);
        check(starts, 1);
        status(8'h03);
        finish_write();
        status(8'h84);
    endtask
    task automatic t_hw_lock;
        wp_n <= 1'b0;
        repeat (6) @(posedge clk);
        check(hardware_lock_mode, 1'b1);
        frame(8, 48'h06);
        frame(16, 48'h0100);
        check(starts, 1);
        status(8'h86);
        supply_droop <= 1'b1;
        repeat (4) @(posedge clk);
        supply_droop <= 1'b0;
        status(8'h84);
        wp_n <= 1'b1;
        repeat (6) @(posedge clk);
        check(hardware_lock_mode, 1'b0);
    endtask
    task automatic t_mem_write;
        frame(8, 48'h06);
        frame(40, 48'h02C03FA15B);
        check(starts, 2);
        check(wq[0], {14'h003F, 8'hA1});
        check(wq[1], {14'h0000, 8'h5B});
        finish_write();
        status(8'h84);
        frame(8, 48'h06);
        frame(32, 48'h023000C3);
        check(starts, 2);
        check(wq.size(), 2);
        frame(8, 48'h04);
    endtask
    task automatic t_mem_read;
        frame(40, 48'h03D2340000);
        check(rx[15:8], 8'h34 ^ 8'h5A);
        check(rx[7:0], 8'h35 ^ 8'h5A);
    endtask
    task automatic t_misc;
        frame(16, 48'hFFFF);
        check(spi_host_model_inst.oe_seen, 1'b0);
        spi_host_model_inst.sel();
        spi_host_model_inst.shift(8, 48'h05, rx);
        hold_n <= 1'b0;
        spi_host_model_inst.shift(8, 48'h00, rx);
        check(spi_host_model_inst.oe_seen, 1'b0);
        hold_n <= 1'b1;
        spi_host_model_inst.shift(8, 48'h00, rx);
        spi_host_model_inst.desel();
        check(rx[7:0], 8'h84);
    endtask

    initial begin
        reset = 1'b1;
        hold_n = 1'b1;
        wp_n = 1'b1;
        supply_droop = 1'b0;
        nv_write_done = 1'b0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        t_latch();
        t_stat_write();
        t_hw_lock();
        t_mem_write();
        t_mem_read();
        t_misc();
        complete_run();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule
